// file: pbr_top.sv
// Bridge pulse generator top: bus slave, channels, routing, trip
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module pbr_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pbr_pkg::pbr_cnt_t fe_sense0,
    input wire pbr_pkg::pbr_cnt_t fe_sense1,
    input wire pbr_pkg::pbr_cnt_t fe_sense2,
    input wire pbr_pkg::pbr_cnt_t filt0_out,
    input wire pbr_pkg::pbr_cnt_t filt1_out,
    output logic [3:0] pwm_a_q,
    output logic [3:0] pwm_b_q,
    output logic comp_rst_q
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic accept;
    logic wr_q, wr_d, rd_q, rd_d;
    logic [7:0] adr_q, adr_d;
    logic hready_d;
    logic [31:0] hrdata_d, rdata_v;

    logic [31:0] ctrl_q, ctrl_d;
    pbr_pkg::pbr_cnt_t period_q, period_d, step_q, step_d;
    pbr_pkg::pbr_cnt_t final_q, final_d;
    logic [15:0] mux_q, mux_d, edge_q, edge_d;
    pbr_pkg::pbr_chcfg_s cfg_q [4];
    pbr_pkg::pbr_chcfg_s cfg_d [4];

    pbr_pkg::pbr_cnt_t cnt_q, cnt_d, ramp_q, fe_val, start_val;
    logic frame, trip_q, trip_d;
    pbr_pkg::pbr_out_s och [4];
    pbr_pkg::pbr_chcfg_s cfg_eff [4];
    logic [3:0] lim, ch_trip, pa_q, pb_q, rise_a, rise_b, fall_a, fall_b;
    logic [7:0] evv;
    logic eg_a_q, eg_a_d, eg_b_q, eg_b_d, eg_en;
    logic [3:0] pwm_a_d, pwm_b_d;
    logic comp_rst_d;
    logic [3:0] sel2a, sel2b, sel3a, sel3b;
    logic [2:0] a_on, a_off, b_on, b_off;
    logic [1:0] fe_sel;

    assign accept = hsel && hready && htrans[1];

    // Address phase capture; reads take one wait state
    always_comb begin
        wr_d = accept && hwrite;
        rd_d = accept && !hwrite;
        adr_d = accept ? haddr[7:0] : adr_q;
        hready_d = !(accept && !hwrite);
        hrdata_d = rd_q ? rdata_v : hrdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            adr_q <= adr_d;
            hreadyout <= hready_d;
            hresp <= 1'b0;
            hrdata <= hrdata_d;
        end
    end

    // Register writes in the data phase
    always_comb begin
        ctrl_d = ctrl_q;
        period_d = period_q;
        step_d = step_q;
        final_d = final_q;
        mux_d = mux_q;
        edge_d = edge_q;
        cfg_d = cfg_q;
        if (wr_q) begin
            case (adr_q)
                pbr_pkg::CTRL_OFS: ctrl_d = hwdata;
                pbr_pkg::PERIOD_OFS: period_d = hwdata[13:0];
                pbr_pkg::STEP_OFS: step_d = hwdata[13:0];
                pbr_pkg::FINAL_OFS: final_d = hwdata[13:0];
                pbr_pkg::MUX_OFS: mux_d = hwdata[15:0];
                pbr_pkg::EDGE_OFS: edge_d = hwdata[15:0];
                default: begin
                    if (adr_q[7:6] == pbr_pkg::CH_PAGE) begin
                        case (adr_q[3:2])
                            pbr_pkg::CH_EV12: begin
                                cfg_d[adr_q[5:4]].ev1 = hwdata[13:0];
                                cfg_d[adr_q[5:4]].ev2 = hwdata[pbr_pkg::HI +: 14];
                            end
                            pbr_pkg::CH_EV34: begin
                                cfg_d[adr_q[5:4]].ev3 = hwdata[13:0];
                                cfg_d[adr_q[5:4]].ev4 = hwdata[pbr_pkg::HI +: 14];
                            end
                            pbr_pkg::CH_BLK: begin
                                cfg_d[adr_q[5:4]].blk_beg = hwdata[13:0];
                                cfg_d[adr_q[5:4]].blk_fin = hwdata[pbr_pkg::HI +: 14];
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    // Read data selection; unmapped reads as zero
    always_comb begin
        rdata_v = 32'h0000_0000;
        case (adr_q)
            pbr_pkg::CTRL_OFS: rdata_v = ctrl_q;
            pbr_pkg::PERIOD_OFS: rdata_v[13:0] = period_q;
            pbr_pkg::STEP_OFS: rdata_v[13:0] = step_q;
            pbr_pkg::FINAL_OFS: rdata_v[13:0] = final_q;
            pbr_pkg::MUX_OFS: rdata_v[15:0] = mux_q;
            pbr_pkg::EDGE_OFS: rdata_v[15:0] = edge_q;
            pbr_pkg::STAT_OFS: begin
                rdata_v[pbr_pkg::HI +: 14] = ramp_q;
                rdata_v[15] = trip_q;
                rdata_v[9] = eg_a_q;
                rdata_v[8] = eg_b_q;
                rdata_v[7:4] = pwm_a_q;
                rdata_v[3:0] = pwm_b_q;
            end
            default: begin
                if (adr_q[7:6] == pbr_pkg::CH_PAGE) begin
                    case (adr_q[3:2])
                        pbr_pkg::CH_EV12: begin
                            rdata_v[13:0] = cfg_q[adr_q[5:4]].ev1;
                            rdata_v[pbr_pkg::HI +: 14] = cfg_q[adr_q[5:4]].ev2;
                        end
                        pbr_pkg::CH_EV34: begin
                            rdata_v[13:0] = cfg_q[adr_q[5:4]].ev3;
                            rdata_v[pbr_pkg::HI +: 14] = cfg_q[adr_q[5:4]].ev4;
                        end
                        pbr_pkg::CH_BLK: begin
                            rdata_v[13:0] = cfg_q[adr_q[5:4]].blk_beg;
                            rdata_v[pbr_pkg::HI +: 14] = cfg_q[adr_q[5:4]].blk_fin;
                        end
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= pbr_pkg::CTRL_RST;
            period_q <= pbr_pkg::PERIOD_RST;
            step_q <= '0;
            final_q <= '0;
            mux_q <= 16'h0000;
            edge_q <= 16'h0000;
            for (int i = 0; i < 4; i++) begin
                cfg_q[i] <= '0;
            end
        end else begin
            ctrl_q <= ctrl_d;
            period_q <= period_d;
            step_q <= step_d;
            final_q <= final_d;
            mux_q <= mux_d;
            edge_q <= edge_d;
            cfg_q <= cfg_d;
        end
    end

    // ****************************************
    // Frame counter, ramp and peak trip
    // ****************************************
    assign frame = (cnt_q == '0);
    assign fe_sel = ctrl_q[pbr_pkg::CTRL_FE_SEL +: 2];
    assign lim = ctrl_q[pbr_pkg::CTRL_LIM +: 4];

    // Period count and trip compare
    always_comb begin
        cnt_d = (cnt_q >= period_q) ? '0 : cnt_q + 14'h0001;
        case (fe_sel)
            2'h0: fe_val = fe_sense0;
            2'h1: fe_val = fe_sense1;
            default: fe_val = fe_sense2;
        endcase
        start_val = ctrl_q[pbr_pkg::CTRL_FILT_SEL] ? filt1_out : filt0_out;
        trip_d = ctrl_q[pbr_pkg::CTRL_PEAK_EN] && ctrl_q[pbr_pkg::CTRL_D2S]
            && (ramp_q > fe_val);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            trip_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            trip_q <= trip_d;
        end
    end

    // Ramp runs only with a filter start source
    pbr_ramp u_ramp (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ctrl_q[pbr_pkg::CTRL_RAMP_EN] && ctrl_q[pbr_pkg::CTRL_START_SEL]),
        .sync_en(ctrl_q[pbr_pkg::CTRL_FRAME_SYNC]),
        .frame(frame),
        .start_val(start_val),
        .step(step_q),
        .fin(final_q),
        .ramp_q(ramp_q)
    );

    // ****************************************
    // Channels
    // ****************************************
    for (genvar i = 0; i < 4; i++) begin : g_ch
        always_comb begin
            cfg_eff[i] = cfg_q[i];
            if (ctrl_q[pbr_pkg::CTRL_VMODE]) begin
                cfg_eff[i].ev2 = filt0_out;
            end
        end
        assign ch_trip[i] = trip_q && lim[i];
        assign rise_a[i] = och[i].a && !pa_q[i];
        assign fall_a[i] = !och[i].a && pa_q[i];
        assign rise_b[i] = och[i].b && !pb_q[i];
        assign fall_b[i] = !och[i].b && pb_q[i];
        pbr_chan u_ch (
            .hclk(hclk),
            .hresetn(hresetn),
            .cnt(cnt_q),
            .frame(frame),
            .cfg(cfg_eff[i]),
            .trip(ch_trip[i]),
            .out_q(och[i])
        );
    end

    // ****************************************
    // Edge generator and output routing
    // ****************************************
    assign sel2a = mux_q[pbr_pkg::MUX_2A +: 4];
    assign sel2b = mux_q[pbr_pkg::MUX_2B +: 4];
    assign sel3a = mux_q[pbr_pkg::MUX_3A +: 4];
    assign sel3b = mux_q[pbr_pkg::MUX_3B +: 4];
    assign a_on = edge_q[pbr_pkg::EG_A_ON +: 3];
    assign a_off = edge_q[pbr_pkg::EG_A_OFF +: 3];
    assign b_on = edge_q[pbr_pkg::EG_B_ON +: 3];
    assign b_off = edge_q[pbr_pkg::EG_B_OFF +: 3];
    assign eg_en = ctrl_q[pbr_pkg::CTRL_EDGE_EN + 2];
    assign evv = {fall_b[3], rise_b[3], fall_a[3], rise_a[3],
        fall_b[2], rise_b[2], fall_a[2], rise_a[2]};

    // Edge set and clear, then pin routing
    always_comb begin
        eg_a_d = eg_a_q;
        eg_b_d = eg_b_q;
        if (eg_en) begin
            if (evv[a_on]) begin
                eg_a_d = 1'b1;
            end else if (evv[a_off]) begin
                eg_a_d = 1'b0;
            end
            if (evv[b_on]) begin
                eg_b_d = 1'b1;
            end else if (evv[b_off]) begin
                eg_b_d = 1'b0;
            end
        end
        pwm_a_d[0] = och[0].a;
        pwm_b_d[0] = och[0].b;
        pwm_a_d[1] = och[1].a;
        pwm_b_d[1] = och[1].b;
        pwm_a_d[2] = (sel2a == pbr_pkg::MUX_EDGE) ? eg_a_q : och[2].a;
        pwm_b_d[2] = (sel2b == pbr_pkg::MUX_EDGE) ? eg_b_q : och[2].b;
        pwm_a_d[3] = (sel3a == pbr_pkg::MUX_CH1C) ? och[1].c :
            (sel3a == pbr_pkg::MUX_CH2C) ? och[2].c : och[3].a;
        pwm_b_d[3] = (sel3b == pbr_pkg::MUX_CH1C) ? och[1].c :
            (sel3b == pbr_pkg::MUX_CH2C) ? och[2].c : och[3].b;
        comp_rst_d = ctrl_q[pbr_pkg::CTRL_EXT_SLOPE] && (rise_a[1] || rise_b[1]);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_q <= 4'h0;
            pb_q <= 4'h0;
            eg_a_q <= 1'b0;
            eg_b_q <= 1'b0;
            pwm_a_q <= 4'h0;
            pwm_b_q <= 4'h0;
            comp_rst_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pa_q[i] <= och[i].a;
                pb_q[i] <= och[i].b;
            end
            eg_a_q <= eg_a_d;
            eg_b_q <= eg_b_d;
            pwm_a_q <= pwm_a_d;
            pwm_b_q <= pwm_b_d;
            comp_rst_q <= comp_rst_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_route_c1;
        @(posedge hclk) disable iff (!hresetn)
        sel3a == pbr_pkg::MUX_CH1C |=> pwm_a_q[3] == $past(och[1].c);
    endproperty
    a_route_c1: assert property (p_route_c1) else $error("Ch3 A not ch1 C");

    property p_route_c2;
        @(posedge hclk) disable iff (!hresetn)
        sel3b == pbr_pkg::MUX_CH2C |=> pwm_b_q[3] == $past(och[2].c);
    endproperty
    a_route_c2: assert property (p_route_c2) else $error("Ch3 B not ch2 C");

    property p_eg_route;
        @(posedge hclk) disable iff (!hresetn)
        sel2a == pbr_pkg::MUX_EDGE |=> pwm_a_q[2] == $past(eg_a_q);
    endproperty
    a_eg_route: assert property (p_eg_route) else $error("Ch2 A not edge A");

    property p_eg_set;
        @(posedge hclk) disable iff (!hresetn)
        eg_en && evv[a_on] |=> eg_a_q ##1 pwm_a_q[2] || sel2a != pbr_pkg::MUX_EDGE;
    endproperty
    a_eg_set: assert property (p_eg_set) else $error("Edge A not set");

    property p_eg_clr;
        @(posedge hclk) disable iff (!hresetn)
        eg_en && evv[b_off] && !evv[b_on] |=> !eg_b_q;
    endproperty
    a_eg_clr: assert property (p_eg_clr) else $error("Edge B not cleared");

    property p_trip;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q[pbr_pkg::CTRL_PEAK_EN] && ctrl_q[pbr_pkg::CTRL_D2S] && ramp_q > fe_val
            |=> trip_q;
    endproperty
    a_trip: assert property (p_trip) else $error("Peak trip missing");

    property p_lim;
        @(posedge hclk) disable iff (!hresetn)
        !lim[2] |-> !ch_trip[2];
    endproperty
    a_lim: assert property (p_lim) else $error("Trip reached unrouted ch");

    property p_comp;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q[pbr_pkg::CTRL_EXT_SLOPE] && rise_b[1] |=> comp_rst_q ##1 !comp_rst_q;
    endproperty
    a_comp: assert property (p_comp) else $error("Compensator reset missing");

    property p_rd_wait;
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("Read wait state wrong");

    c_eg: cover property (@(posedge hclk) disable iff (!hresetn) eg_en && evv[a_on]);
    c_trip: cover property (@(posedge hclk) disable iff (!hresetn) trip_q && lim[0]);
    c_read: cover property (@(posedge hclk) disable iff (!hresetn) rd_q);
endmodule : pbr_top

// file: pbr_pkg.sv
// Constants and types for the peak current bridge pulse generator
package pbr_pkg;
    localparam int CW = 14;
    typedef logic [CW-1:0] pbr_cnt_t;
    typedef struct packed {
        pbr_cnt_t ev1;
        pbr_cnt_t ev2;
        pbr_cnt_t ev3;
        pbr_cnt_t ev4;
        pbr_cnt_t blk_beg;
        pbr_cnt_t blk_fin;
    } pbr_chcfg_s;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } pbr_out_s;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PERIOD_OFS = 8'h04;
    localparam logic [7:0] STEP_OFS = 8'h08;
    localparam logic [7:0] FINAL_OFS = 8'h0C;
    localparam logic [7:0] MUX_OFS = 8'h10;
    localparam logic [7:0] EDGE_OFS = 8'h14;
    localparam logic [7:0] STAT_OFS = 8'h18;
    localparam logic [1:0] CH_PAGE = 2'h1;
    localparam logic [1:0] CH_EV12 = 2'h0;
    localparam logic [1:0] CH_EV34 = 2'h1;
    localparam logic [1:0] CH_BLK = 2'h2;
    localparam int HI = 16;
    localparam int CTRL_RAMP_EN = 0;
    localparam int CTRL_START_SEL = 1;
    localparam int CTRL_FILT_SEL = 2;
    localparam int CTRL_FRAME_SYNC = 3;
    localparam int CTRL_PEAK_EN = 4;
    localparam int CTRL_FE_SEL = 5;
    localparam int CTRL_VMODE = 7;
    localparam int CTRL_EXT_SLOPE = 8;
    localparam int CTRL_D2S = 9;
    localparam int CTRL_LIM = 16;
    localparam int CTRL_EDGE_EN = 20;
    localparam int MUX_2A = 0;
    localparam int MUX_2B = 4;
    localparam int MUX_3A = 8;
    localparam int MUX_3B = 12;
    localparam int EG_A_ON = 0;
    localparam int EG_A_OFF = 4;
    localparam int EG_B_ON = 8;
    localparam int EG_B_OFF = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam pbr_cnt_t PERIOD_RST = 14'h0FFF;
    localparam logic [3:0] MUX_EDGE = 4'h1;
    localparam logic [3:0] MUX_CH1C = 4'h7;
    localparam logic [3:0] MUX_CH2C = 4'h8;
    // ****************************************
    // Ramp timing
    // ****************************************
    localparam int CLK_NS = 5;
    localparam int RAMP_STEP_NS = 32;
    localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] RAMP_DIV_LAST = 3'(RAMP_STEP_CYC - 1);
endpackage : pbr_pkg

// file: pbr_chan.sv
// One normal-mode pulse channel with cycle limiting and C waveform
`timescale 1ns/100ps
module pbr_chan (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pbr_pkg::pbr_cnt_t cnt,
    input wire logic frame,
    input wire pbr_pkg::pbr_chcfg_s cfg,
    input wire logic trip,
    output pbr_pkg::pbr_out_s out_q
);
    logic chop_q, chop_d;
    pbr_pkg::pbr_cnt_t brise_q, brise_d;
    pbr_pkg::pbr_out_s out_d;
    logic win_a;

    assign win_a = (cnt >= cfg.ev1) && (cnt < cfg.ev2);

    // Chop state, B rise position and outputs
    always_comb begin
        chop_d = chop_q;
        brise_d = brise_q;
        if (frame) begin
            chop_d = 1'b0;
            brise_d = cfg.ev3;
        end else if (trip && out_q.a && !chop_q) begin
            chop_d = 1'b1;
            brise_d = cnt + (cfg.ev3 - cfg.ev2);
        end
        out_d.a = win_a && !chop_d;
        out_d.b = (cnt >= brise_d) && (cnt < cfg.ev4);
        out_d.c = (cnt >= cfg.blk_beg) && (cnt < cfg.blk_fin);
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chop_q <= 1'b0;
            brise_q <= '0;
            out_q <= '0;
        end else begin
            chop_q <= chop_d;
            brise_q <= brise_d;
            out_q <= out_d;
        end
    end

    property p_chop;
        @(posedge hclk) disable iff (!hresetn)
        trip && out_q.a && !chop_q && !frame |=> !out_q.a;
    endproperty
    a_chop: assert property (p_chop) else $error("A not chopped by trip");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        chop_q && !frame |=> !out_q.a;
    endproperty
    a_hold: assert property (p_hold) else $error("Chopped A rose early");

    property p_open;
        @(posedge hclk) disable iff (!hresetn)
        !chop_q && !frame && !trip |=> out_q.a == $past(win_a);
    endproperty
    a_open: assert property (p_open) else $error("A differs from events");

    c_chop: cover property (@(posedge hclk) disable iff (!hresetn) chop_d && !chop_q);
endmodule : pbr_chan

// file: pbr_ramp.sv
// Compensation ramp restarted per frame and stepped on a divider
`timescale 1ns/100ps
module pbr_ramp (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic sync_en,
    input wire logic frame,
    input wire pbr_pkg::pbr_cnt_t start_val,
    input wire pbr_pkg::pbr_cnt_t step,
    input wire pbr_pkg::pbr_cnt_t fin,
    output pbr_pkg::pbr_cnt_t ramp_q
);
    logic [2:0] div_q, div_d;
    pbr_pkg::pbr_cnt_t ramp_d;
    logic tick;

    assign tick = (div_q == pbr_pkg::RAMP_DIV_LAST);

    // Step divider and ramp value
    always_comb begin
        div_d = tick ? 3'h0 : div_q + 3'h1;
        ramp_d = ramp_q;
        if (run && sync_en && frame) begin
            div_d = 3'h0;
            ramp_d = start_val;
        end else if (run && tick && (ramp_q > fin)) begin
            ramp_d = ((ramp_q - fin) > step) ? ramp_q - step : fin;
        end
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 3'h0;
            ramp_q <= '0;
        end else begin
            div_q <= div_d;
            ramp_q <= ramp_d;
        end
    end

    property p_restart;
        @(posedge hclk) disable iff (!hresetn)
        run && sync_en && frame |=> ramp_q == $past(start_val);
    endproperty
    a_restart: assert property (p_restart) else $error("Ramp missed restart");

    property p_still;
        @(posedge hclk) disable iff (!hresetn)
        !tick && !(sync_en && frame) |=> $stable(ramp_q);
    endproperty
    a_still: assert property (p_still) else $error("Ramp moved off tick");
endmodule : pbr_ramp

// file: pbr_gate_drv.sv
// Gate driver model that measures pulse widths and dead time
`timescale 1ns/100ps
module pbr_gate_drv (
    input wire logic clk,
    input wire logic rstn,
    input wire logic a,
    input wire logic b,
    output logic [31:0] wid_a,
    output logic [31:0] wid_b,
    output logic [31:0] gap
);
    logic a_q, b_q;
    logic [31:0] ca, cb, cg;
    // Count high cycles and the A fall to B rise spacing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {a_q, b_q, ca, cb, cg, wid_a, wid_b, gap} <= '0;
        end else begin
            a_q <= a;
            b_q <= b;
            ca <= a ? ca + 32'h1 : 32'h0;
            cb <= b ? cb + 32'h1 : 32'h0;
            cg <= (a_q && !a) ? 32'h1 : cg + 32'h1;
            if (a_q && !a) wid_a <= ca;
            if (b_q && !b) wid_b <= cb;
            if (b && !b_q) gap <= cg;
        end
    end
endmodule : pbr_gate_drv

// file: tb_pbr_top.sv
// Testbench for the bridge pulse generator
`timescale 1ns/100ps
module tb_pbr_top;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, wa0, wb0, g0, wa3, wb3, wa2, wb2, g2, wc1, gc1;
    logic crst;
    pbr_pkg::pbr_cnt_t fe0, fe1, fe2, flt0, flt1;
    logic [3:0] pa, pb;
    int fails, samples_checked;
    pbr_top i_pbr_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fe_sense0(fe0),
        .fe_sense1(fe1), .fe_sense2(fe2), .filt0_out(flt0), .filt1_out(flt1),
        .pwm_a_q(pa), .pwm_b_q(pb), .comp_rst_q(crst));
    pbr_gate_drv i_pbr_gate_drv0 (.clk(hclk), .rstn(hresetn), .a(pa[0]), .b(pb[0]),
        .wid_a(wa0), .wid_b(wb0), .gap(g0));
    pbr_gate_drv i_pbr_gate_drv3 (.clk(hclk), .rstn(hresetn), .a(pa[3]), .b(pb[3]),
        .wid_a(wa3), .wid_b(wb3), .gap());
    pbr_gate_drv i_pbr_gate_drv2 (.clk(hclk), .rstn(hresetn), .a(pa[2]), .b(pb[2]),
        .wid_a(wa2), .wid_b(wb2), .gap(g2));
    pbr_gate_drv i_pbr_gate_drv1 (.clk(hclk), .rstn(hresetn), .a(crst), .b(pb[1]),
        .wid_a(wc1), .wid_b(), .gap(gc1));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
        rd = hrdata;
        if (n >= 50) begin
            fails++;
            print_verdict();
        end
    endtask : bus
    task automatic settle;
        repeat (130) @(posedge hclk);
    endtask : settle
    // Free running clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // Main sequence
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        {fe0, fe1, fe2, flt0, flt1} = '0;
        fails = 0;
        samples_checked = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0FFF);
        bus(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
        bus(1'b1, 8'h04, 32'h28);
        bus(1'b1, 8'h00, 32'h00F00000);
        bus(1'b1, 8'h54, 32'h001E0014);
        bus(1'b1, 8'h60, 32'h000C0002);
        bus(1'b1, 8'h64, 32'h00240016);
        bus(1'b1, 8'h70, 32'h001E0014);
        bus(1'b1, 8'h74, 32'h00260022);
        bus(1'b1, 8'h14, 32'h00001652);
        bus(1'b1, 8'h40, 32'h000C0002);
        bus(1'b1, 8'h44, 32'h001E0010);
        bus(1'b1, 8'h58, 32'h00190005);
        bus(1'b1, 8'h68, 32'h00090003);
        bus(1'b1, 8'h10, 32'h00008711);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h000C0002);
        settle();
        chk(wa0, 32'hA);
        chk(wb0, 32'hE);
        chk(g0, 32'h4);
        chk(wa3, 32'h14);
        chk(wb3, 32'h6);
        chk(wa2, 32'h8);
        chk(wb2, 32'h13);
        chk(g2, 32'h4);
        flt0 <= 14'h3000;
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h00, 32'h00FF525B);
        settle();
        chk(32'(wa0 < 32'hA), 32'h1);
        chk(g0, 32'h4);
        flt0 <= 14'h0;
        flt1 <= 14'h3000;
        fe2 <= 14'h0100;
        settle();
        chk(wa0, 32'hA);
        bus(1'b1, 8'h00, 32'h00FF525F);
        settle();
        chk(32'(wa0 < 32'hA), 32'h1);
        flt0 <= 14'h8;
        bus(1'b1, 8'h00, 32'h00000180);
        settle();
        chk(wa0, 32'h6);
        chk(g0, 32'h8);
        chk(wc1, 32'h1);
        chk(gc1, 32'h13);
        print_verdict();
    end
endmodule : tb_pbr_top
